// *** core/cusb_clock_map.vh ***
/*
  Bit positions, reset values and timing figures of the CPU and USB clock
  selector. Assumes it is included by the selector modules only.
*/
// Notes on behaviour
// (RL1) PLL stopped while halt bit is one
// (RL2) Multiplier select: zero times 8, one times 12
// (RL3) Source select one feeds HS clock to PLL
// (RL4) Software stops, programs, selects, then starts PLL
// (RL5) Software waits 800 us before USB clock
// (RL6) USB gate bit passes PLL clock to core
// (RL7) Internal, X1 or external clock per selects
// (RL8) Oscillator mode: bits 7, 6, 0
// (RL9) CPU source select at bit 4
// (RL10) Main clock mode: bits 2 and 0
// (RL11) HS oscillator halt at bit 7
// (RL12) Internal osc: stable bit 7, halt bit 0
// (RL13) CPU runs internal oscillator after reset
// (RL14) Amplitude high only above 10 MHz
// (RL15) Software prepares oscillator before switching CPU
// (RL16) Amplitude and PLL source select write once
// (RL17) No return from HS clock to internal
// (RL18) HALT from HS clock enters HALT mode
// (RL19) Software stops peripherals before STOP
// (RL20) Source switching is glitch free; the X1/external select switches at once, outside the mux
`ifndef CUSB_CLOCK_MAP_VH
`define CUSB_CLOCK_MAP_VH

`define CUSB_OSC_EXTCLK_BIT   7
`define CUSB_OSC_PINEN_BIT    6
`define CUSB_OSC_AMPLITUDE_HIGH_BIT     0
`define CUSB_PROC_CSS_BIT     4
`define CUSB_MCM_HS_SOURCE_TO_PLL_SEL_BIT     2
`define CUSB_MCM_MAIN_BIT     0
`define CUSB_MOC_HALT_BIT     7
`define CUSB_RCM_STABLE_BIT   7
`define CUSB_RCM_HALT_BIT     0
`define CUSB_PLL_HALT_BIT     1
`define CUSB_PLL_MUL_BIT      0
`define CUSB_USB_GATE_BIT     0

`define CUSB_PLL_HALT_RST     1'h1
`define CUSB_MUL_LOW          5'h08
`define CUSB_MUL_HIGH         5'h0C

`define CUSB_CLK_MHZ          25
`define CUSB_PLL_LOCK_US      800
`define CUSB_PLL_LOCK_CYC     (`CUSB_PLL_LOCK_US * `CUSB_CLK_MHZ)
`define CUSB_INT_STABLE_CYC   16'h0010

`endif

// *** core/cusb_clk_mux.v ***
/*
  Two-input glitch-free clock enable switch. Inputs are enable pulses in the
  clk domain; the switch changes source only between pulses of both.
*/
`timescale 1ns/100ps
`default_nettype none
module cusb_clk_mux
(
  input  wire clk,
  input  wire sys_rst,
  input  wire selB,
  input  wire tickA,
  input  wire tickB,
  output wire tickOut,
  output wire onB
);
  reg selB_ff;

  always @(posedge clk)
  begin
    if (sys_rst)
      selB_ff <= 1'b0;
    else if (!tickA && !tickB)
      selB_ff <= selB; // see (RL20)
  end

  assign onB     = selB_ff;
  assign tickOut = selB_ff ? tickB : tickA;
endmodule // cusb_clk_mux
`default_nettype wire

// *** core/cusb_clock_selector.v ***
/*
  CPU, peripheral and USB clock selector. Clock sources arrive as one-cycle
  enable pulses in the single clk domain; selected enables leave the same way.
  Control bits are plain ports written by the core via write strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cusb_clock_map.vh"
module cusb_clock_selector
#(
  parameter LOCK_CYC = `CUSB_PLL_LOCK_CYC
)
(
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       intOscTick,
  input  wire       hsOscTick,
  input  wire       extClkTick,
  input  wire [7:0] wrData,
  input  wire       oscModeWr,
  input  wire       procClockWr,
  input  wire       mainModeWr,
  input  wire       mainOscWr,
  input  wire       intOscWr,
  input  wire       pllControlWr,
  input  wire       usbControlWr,
  input  wire       haltExec,
  input  wire       stopExec,
  input  wire       wakeUp,
  output wire [7:0] oscModeRd,
  output wire [7:0] procClockRd,
  output wire [7:0] mainModeRd,
  output wire [7:0] mainOscRd,
  output wire [7:0] intOscRd,
  output wire [7:0] pllControlRd,
  output wire       cpuTick,
  output wire       periphTick,
  output wire       usbTick,
  output reg        pllTick_ff,
  output wire       pllLocked,
  output wire [4:0] pllFactor,
  output wire       haltMode,
  output wire       stopMode
);
  localparam RUN  = 2'h0;
  localparam HALT = 2'h1;
  localparam STOP = 2'h2;

  reg        extSel_ff, pinEn_ff, amplitude_high_ff, amphDone_ff;
  reg        cssSel_ff, hs_source_to_pll_sel_ff, xselDone_ff, mainSel_ff;
  reg        hsHalt_ff, intHalt_ff, intStable_ff;
  reg        pllHalt_ff, pllMul_ff, usbGate_ff, hsLock_ff;
  reg [1:0]  mode_ff;
  reg [1:0]  nxt_mode;
  reg [15:0] intCnt_ff;
  reg [31:0] lockCnt_ff;
  reg [4:0]  pllPh_ff;
  wire       hsTick, hsSrcTick, mainTick, onHs, gateOpen;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      extSel_ff   <= 1'b0;
      pinEn_ff    <= 1'b0;
      amplitude_high_ff     <= 1'b0;
      amphDone_ff <= 1'b0;
      cssSel_ff   <= 1'b0;
      hs_source_to_pll_sel_ff     <= 1'b0;
      xselDone_ff <= 1'b0;
      mainSel_ff  <= 1'b0; // see (RL13)
      hsHalt_ff   <= 1'b1;
      intHalt_ff  <= 1'b0;
      pllHalt_ff  <= `CUSB_PLL_HALT_RST;
      pllMul_ff   <= 1'b0;
      usbGate_ff  <= 1'b0;
      hsLock_ff   <= 1'b0;
    end
    else
    begin
      if (oscModeWr)
      begin
        extSel_ff <= wrData[`CUSB_OSC_EXTCLK_BIT]; // see (RL8)
        pinEn_ff  <= wrData[`CUSB_OSC_PINEN_BIT];
        if (!amphDone_ff)
        begin
          amplitude_high_ff     <= wrData[`CUSB_OSC_AMPLITUDE_HIGH_BIT]; // see (RL16)
          amphDone_ff <= 1'b1;
        end
      end
      if (procClockWr)
        cssSel_ff <= wrData[`CUSB_PROC_CSS_BIT]; // see (RL9)
      if (mainModeWr)
      begin
        if (!xselDone_ff)
        begin
          hs_source_to_pll_sel_ff     <= wrData[`CUSB_MCM_HS_SOURCE_TO_PLL_SEL_BIT]; // see (RL10) (RL16)
          xselDone_ff <= 1'b1;
        end
        if (wrData[`CUSB_MCM_MAIN_BIT])
          mainSel_ff <= 1'b1; // see (RL17)
      end
      if (mainOscWr)
        hsHalt_ff <= wrData[`CUSB_MOC_HALT_BIT]; // see (RL11)
      if (intOscWr)
        intHalt_ff <= wrData[`CUSB_RCM_HALT_BIT]; // see (RL12)
      if (pllControlWr)
      begin
        pllHalt_ff <= wrData[`CUSB_PLL_HALT_BIT]; // see (RL1)
        pllMul_ff  <= wrData[`CUSB_PLL_MUL_BIT]; // see (RL2)
      end
      if (usbControlWr)
        usbGate_ff <= wrData[`CUSB_USB_GATE_BIT]; // see (RL6)
      hsLock_ff <= onHs;
    end
  end

  // Internal oscillator settles after restart
  always @(posedge clk)
  begin
    if (sys_rst || intHalt_ff)
    begin
      intCnt_ff    <= 16'h0000;
      intStable_ff <= 1'b0;
    end
    else if (intOscTick && !intStable_ff)
    begin
      intCnt_ff    <= intCnt_ff + 16'h0001;
      intStable_ff <= (intCnt_ff == `CUSB_INT_STABLE_CYC - 16'h0001);
    end
  end

  // High-speed source: X1 or external, gated by pin enable and halt
  assign hsTick    = pinEn_ff && !hsHalt_ff &&
                     (extSel_ff ? extClkTick : hsOscTick); // see (RL7)
  assign hsSrcTick = hs_source_to_pll_sel_ff && hsTick; // see (RL3)

  cusb_clk_mux mainMux
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .selB    (mainSel_ff && hs_source_to_pll_sel_ff),
    .tickA   (intOscTick && !intHalt_ff),
    .tickB   (hsTick),
    .tickOut (mainTick),
    .onB     (onHs)
  );

  // PLL model: multiplies source enables into a phase counter
  assign pllFactor = pllMul_ff ? `CUSB_MUL_HIGH : `CUSB_MUL_LOW; // see (RL2)
  always @(posedge clk)
  begin
    if (sys_rst || pllHalt_ff || !hs_source_to_pll_sel_ff)
    begin
      pllPh_ff   <= 5'h00; // see (RL1)
      pllTick_ff <= 1'b0;
      lockCnt_ff <= 32'h00000000;
    end
    else
    begin
      pllTick_ff <= hsSrcTick || (pllPh_ff != 5'h00);
      if (hsSrcTick)
        pllPh_ff <= pllFactor - 5'h01;
      else if (pllPh_ff != 5'h00)
        pllPh_ff <= pllPh_ff - 5'h01;
      if (lockCnt_ff < LOCK_CYC)
        lockCnt_ff <= lockCnt_ff + 32'h00000001;
    end
  end
  // Lock flag drops in the very cycle the halt bit is set
  assign pllLocked = !pllHalt_ff && (lockCnt_ff >= LOCK_CYC); // see (RL1)

  // Low-power modes
  always @*
  begin
    nxt_mode = mode_ff;
    case (mode_ff)
      RUN:
      begin
        if (stopExec)
          nxt_mode = STOP; // see (RL19)
        else if (haltExec)
          nxt_mode = HALT; // see (RL18)
      end
      HALT:
        if (wakeUp)
          nxt_mode = RUN;
      STOP:
        if (wakeUp)
          nxt_mode = RUN;
      default:
        nxt_mode = RUN;
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
      mode_ff <= RUN;
    else
      mode_ff <= nxt_mode;
  end

  assign haltMode   = (mode_ff == HALT);
  assign stopMode   = (mode_ff == STOP);
  assign gateOpen   = (mode_ff == RUN);
  assign cpuTick    = gateOpen && !cssSel_ff && mainTick;
  assign periphTick = !stopMode && mainTick;
  assign usbTick    = usbGate_ff && !stopMode && pllTick_ff; // see (RL6)

  assign oscModeRd    = {extSel_ff, pinEn_ff, 5'h00, amplitude_high_ff};
  assign procClockRd  = {3'h0, cssSel_ff, 4'h0};
  assign mainModeRd   = {5'h00, hs_source_to_pll_sel_ff, hsLock_ff, mainSel_ff};
  assign mainOscRd    = {hsHalt_ff, 7'h00};
  assign intOscRd     = {intStable_ff, 6'h00, intHalt_ff};
  assign pllControlRd = {6'h00, pllHalt_ff, pllMul_ff};
endmodule // cusb_clock_selector
`default_nettype wire

// *** testbench/cusb_sel_chk.sv ***
/* Port checker for the clock selector.
   Assumes one clk domain with a sync reset. */
`timescale 1ns/100ps
`default_nettype none
module cusb_sel_chk
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       intOscTick,
  input wire logic       hsOscTick,
  input wire logic       extClkTick,
  input wire logic       haltExec,
  input wire logic [7:0] procClockRd,
  input wire logic [7:0] mainModeRd,
  input wire logic [7:0] intOscRd,
  input wire logic [7:0] pllControlRd,
  input wire logic       cpuTick,
  input wire logic       usbTick,
  input wire logic       pllTick_ff,
  input wire logic       pllLocked,
  input wire logic [4:0] pllFactor,
  input wire logic       haltMode,
  input wire logic       stopMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_halt_no_lock: assert property
    (pllControlRd[1] |-> !pllLocked ##1 !pllTick_ff)
    else $error("pll locked while halted");
  a_factor_sel: assert property
    (pllFactor == (pllControlRd[0] ? 5'h0C : 5'h08))
    else $error("wrong pll factor");
  a_usb_from_pll: assert property (usbTick |-> pllTick_ff)
    else $error("usb tick without pll tick");
  a_hs_sticky: assert property (mainModeRd[1] |=> mainModeRd[1])
    else $error("cpu left hs clock");
  a_int_default: assert property
    (!mainModeRd[0] && !procClockRd[4] && !intOscRd[0] && !haltMode &&
     !stopMode |-> cpuTick == intOscTick)
    else $error("cpu not on internal osc");
  a_halt_entry: assert property
    (haltExec && mainModeRd[1] |-> ##[1:2] haltMode)
    else $error("halt not entered");
  a_tick_source: assert property
    (cpuTick |-> intOscTick || hsOscTick || extClkTick)
    else $error("cpu tick without source");
  a_osc_unstable: assert property
    (intOscRd[0] && $past(intOscRd[0]) |-> !intOscRd[7])
    else $error("stable while halted");
  c_locked: cover property (pllLocked);
  c_on_hs: cover property (mainModeRd[1]);
  c_halt: cover property (haltMode);
endmodule // cusb_sel_chk
bind cusb_clock_selector cusb_sel_chk u_chk
(
  .clk, .sys_rst, .intOscTick, .hsOscTick, .extClkTick, .haltExec,
  .procClockRd, .mainModeRd, .intOscRd, .pllControlRd, .cpuTick,
  .usbTick, .pllTick_ff, .pllLocked, .pllFactor, .haltMode, .stopMode
);
`default_nettype wire

// *** testbench/tb.sv ***
/* Self-checking bench of the clock selector.
   Assumes the bound checker; sources are sparse enable pulses. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       intOscTick = 1'b0;
  logic       hsOscTick = 1'b0;
  logic       extClkTick = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic [6:0] wrStb = 7'h00;
  logic       haltExec = 1'b0;
  logic       stopExec = 1'b0;
  logic       wakeUp = 1'b0;
  logic [7:0] oscModeRd, procClockRd, mainModeRd, mainOscRd, intOscRd;
  logic [7:0] pllControlRd;
  logic [4:0] pllFactor;
  logic       cpuTick, periphTick, usbTick, pllTick_ff, pllLocked;
  logic       haltMode, stopMode;
  logic [7:0] ticks;
  assign ticks = {6'h00, cpuTick, periphTick};
  int         err_total = 0;
  int         num_checks = 0;
  int         cyc = 0;
  cusb_clock_selector #(.LOCK_CYC(50)) u_dut
  (
    .clk, .sys_rst, .intOscTick, .hsOscTick, .extClkTick, .wrData,
    .oscModeWr(wrStb[0]), .procClockWr(wrStb[1]), .mainModeWr(wrStb[2]),
    .mainOscWr(wrStb[3]), .intOscWr(wrStb[4]), .pllControlWr(wrStb[5]),
    .usbControlWr(wrStb[6]), .haltExec, .stopExec, .wakeUp, .oscModeRd,
    .procClockRd, .mainModeRd, .mainOscRd, .intOscRd, .pllControlRd,
    .cpuTick, .periphTick, .usbTick, .pllTick_ff, .pllLocked,
    .pllFactor, .haltMode, .stopMode
  );
  initial forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    intOscTick <= (cyc % 4 == 3);
    hsOscTick <= (cyc % 5 == 2);
    extClkTick <= (cyc % 7 == 4);
    if (cyc == 3000)
    begin
      err_total++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input int i, input logic [7:0] d);
    @(posedge clk);
    wrStb <= 7'h01 << i;
    wrData <= d;
    @(posedge clk);
    wrStb <= 7'h00;
    @(negedge clk);
  endtask
  task follow(input int s);
    logic e;
    repeat (20)
    begin
      @(negedge clk);
      e = (s == 2) ? extClkTick : (s == 1) ? hsOscTick : intOscTick;
      chk("cpuTick", {7'h00, e}, {7'h00, cpuTick});
    end
  endtask
  task pulse(input int i);
    @(posedge clk);
    {wakeUp, stopExec, haltExec} <= 3'h1 << i;
    @(posedge clk);
    {wakeUp, stopExec, haltExec} <= 3'h0;
    repeat (3) @(negedge clk);
  endtask
  task t_reset();
    chk("pllCtl", 8'h02, pllControlRd & 8'h03);
    chk("mainOsc", 8'h80, mainOscRd & 8'h80);
    chk("mainMode", 8'h00, mainModeRd & 8'h07);
    chk("factor", 8'h08, {3'h0, pllFactor});
    follow(1'b0);
    $display("reset test done");
  endtask
  task t_pll();
    int n;
    logic seen;
    wr(0, 8'h41);
    chk("oscMode", 8'h41, oscModeRd & 8'hC1);
    wr(3, 8'h00);
    chk("mainOsc", 8'h00, mainOscRd & 8'h80);
    wr(5, 8'h03);
    chk("factor", 8'h0C, {3'h0, pllFactor});
    wr(5, 8'h02);
    chk("factor", 8'h08, {3'h0, pllFactor});
    wr(2, 8'h04);
    chk("pllSrc", 8'h04, mainModeRd & 8'h04);
    wr(5, 8'h00);
    n = 0;
    seen = 1'b0;
    while (!pllLocked && n < 200)
    begin
      @(negedge clk);
      seen = seen | usbTick;
      n++;
    end
    chk("lockTime", 8'h01, {7'h00, n > 45 && n < 60});
    chk("usbOff", 8'h00, {7'h00, seen});
    wr(6, 8'h01);
    repeat (60) @(negedge clk) seen = seen | usbTick;
    chk("usbOn", 8'h01, {7'h00, seen});
    $display("pll test done");
  endtask
  task t_once();
    wr(2, 8'h00);
    chk("pllSrc", 8'h04, mainModeRd & 8'h04);
    wr(0, 8'h41);
    wr(0, 8'h40);
    chk("oscMode", 8'h41, oscModeRd & 8'hC1);
    $display("write once test done");
  endtask
  task t_switch();
    wr(2, 8'h05);
    repeat (10) @(negedge clk);
    chk("onHs", 8'h03, mainModeRd & 8'h03);
    follow(1'b1);
    wr(0, 8'hC0);
    follow(2);
    wr(0, 8'h40);
    wr(1, 8'h10);
    chk("procClk", 8'h10, procClockRd);
    repeat (8)
    begin
      @(negedge clk);
      chk("cpuOff", 8'h00, {7'h00, cpuTick});
    end
    wr(1, 8'h00);
    wr(2, 8'h04);
    chk("onHs", 8'h03, mainModeRd & 8'h03);
    wr(4, 8'h01);
    @(negedge clk);
    chk("intOsc", 8'h01, intOscRd & 8'h81);
    wr(4, 8'h00);
    repeat (80) @(negedge clk);
    chk("intOsc", 8'h80, intOscRd & 8'h81);
    $display("switch test done");
  endtask
  task t_halt();
    pulse(0);
    chk("halt", 8'h01, {7'h00, haltMode});
    repeat (10)
    begin
      @(negedge clk);
      chk("haltTck", {7'h00, hsOscTick}, ticks);
    end
    pulse(2);
    pulse(1);
    chk("stop", 8'h01, {7'h00, stopMode});
    repeat (10)
    begin
      @(negedge clk);
      chk("stopTck", 8'h00, ticks);
    end
    pulse(2);
    chk("wake", 8'h00, {6'h00, stopMode, haltMode});
    $display("standby test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_pll();
    t_once();
    t_switch();
    t_halt();
    complete_run();
  end
endmodule // tb
`default_nettype wire
